// ### rtl/rcdt_params.svh
// Purpose: constants of the decode, power-down and timer core
// Assumes: included by bare name wherever a constant is needed
// Notes: bus offsets are byte addresses of aligned 32-bit words
`ifndef RCDT_PARAMS_SVH
`define RCDT_PARAMS_SVH

// ****
// System opcode low fields
// ****
`define RCDT_SYS_SLEEP 7'h03
`define RCDT_SYS_KICK 7'h04
`define RCDT_SYS_RET 7'h40
`define RCDT_SYS_IRQ_EXIT_OP 7'h60

// ****
// Data and write plane addresses
// ****
`define RCDT_F_INDIR 7'h00
`define RCDT_F_TIMER 7'h01
`define RCDT_F_PCL 7'h02
`define RCDT_F_STAT 7'h03
`define RCDT_F_FSR 7'h04
`define RCDT_F_PORT 7'h06
`define RCDT_R_RELOAD 6'h01
`define RCDT_R_PRESCALE 6'h02

// ****
// Status bit positions
// ****
`define RCDT_ST_PAGE 6
`define RCDT_ST_Z 2
`define RCDT_ST_DC 1
`define RCDT_ST_C 0

// ****
// Reset values and timing
// ****
`define RCDT_PORT_RST 8'hFF
`define RCDT_PC_RST 13'h0000
`define RCDT_IRQ_VEC 13'h0001
`define RCDT_STACK_DEPTH 6
`define RCDT_WDOG_OSC_CYCLES 4000000
`define RCDT_T0_MIN_DIV 4

// ****
// Register bus map
// ****
`define RCDT_A_IRQ_EN 8'h00
`define RCDT_A_CORE 8'h04
`define RCDT_A_PC 8'h08
`define RCDT_A_TIMER 8'h0C
`define RCDT_CORE_T0F 19
`define RCDT_RESP_OKAY 2'h0
`define RCDT_RESP_SLVERR 2'h2

`endif

// ### rtl/rcdt_pkg.sv
// Purpose: shared types of the decode, power-down and timer core
// Assumes: constants come from rcdt_params.svh
// Notes: the whole core state is one packed struct
`include "rcdt_params.svh"
package rcdt_pkg;
	// ****
	// Register bus carriers
	// ****
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} rcdt_axi_in_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rcdt_axi_out_type;

	// ****
	// Core state
	// ****
	typedef struct packed {
		logic aw_got;
		logic [7:0] awa;
		logic w_got;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] irq_en;
	} rcdt_bus_type;

	typedef struct packed {
		rcdt_bus_type bus;
		logic [12:0] pc;
		logic [7:0] w;
		logic [7:0] stat;
		logic [7:0] fsr;
		logic [7:0] port;
		logic [7:0] tmr;
		logic [7:0] rld;
		logic [7:0] psc;
		logic [9:0] pcnt;
		logic t0f;
		logic [`RCDT_STACK_DEPTH-1:0][12:0] stk;
		logic [2:0] sp;
		logic bubble;
		logic iflag;
		logic sleep;
		logic wd_en;
		logic [21:0] wd_cnt;
		logic wd_rst;
		logic [15:0][7:0] gpr;
	} rcdt_state_type;
endpackage

// ### rtl/rcdt_core.sv
// Purpose: decode and execute of the 8-bit core with power-down,
//   guard timer and reloading 8-bit timer
// Assumes: instr_i is the ROM word at pc_o in the same cycle
// Notes: one instruction cycle per clock with ce_i high
//
// What this block does
// RULE_01: Sleep opcode takes one cycle and stops the oscillator.
// RULE_02: Kick opcode clears the guard timer and enables it.
// RULE_03: Guard timer is off after any reset until kicked.
// RULE_04: Enabled guard timer resets the chip if not kicked in time.
// RULE_05: Guard timer does not count in power-down.
// RULE_06: Power-down ends on reset or an enabled interrupt.
// RULE_07: Timer is a data register, counts up, reloads at rollover.
// RULE_08: Prescale sets cycles per timer step; zero means four.
// RULE_09: Timer rollover sets its sticky flag.
// RULE_10: Bit set, bit clear and data-destination ops read the latch.
// RULE_11: Rotate right or left through carry, result to chosen place.
// RULE_12: Swap exchanges nibbles of the byte.
// RULE_13: Decrement or increment, skip next when result is zero.
// RULE_14: Bit clear or set of a chosen bit in one cycle.
// RULE_15: Bit test skips next instruction when the bit is clear.
// RULE_16: Bit test skips next instruction when the bit is set.
// RULE_17: Return with literal loads W, takes two cycles.
// RULE_18: Load literal copies it into W.
// RULE_19: OR literal into W, update zero flag.
// RULE_20: AND literal with W, result in W.
// RULE_21: Add literal to W, sum in W.
// RULE_22: XOR literal with W, update zero flag.
// RULE_23: Destination bit 0 writes W, 1 writes the data byte.
// RULE_24: Call and jump take low 12 bits from word, top from page.
// RULE_25: One cycle per opcode, flow changes take two.
// RULE_26: Byte function codes for subtract to increment as listed.
// RULE_27: Prefix 10 calls, 11 jumps; return and interrupt return.
// RULE_28: Code 1000 loads W or only tests the byte for zero.
// RULE_29: All-zero opcode idles; store W into write plane.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "rcdt_params.svh"
module rcdt_core #(
	parameter int unsigned WDOG_LIMIT = `RCDT_WDOG_OSC_CYCLES // Guard timer span
) (
	input wire ref_clk_i, // Core clock
	input wire resetn_i, // Async reset, low
	input wire ce_i, // Clock enable
	input wire [13:0] instr_i, // ROM word at pc_o
	output logic [12:0] pc_o, // Fetch address
	input wire [6:0] irq_i, // Level interrupt sources
	input wire [7:0] port_pin_i, // Port pin levels
	output logic [7:0] port_out_o, // Port latch
	output logic [7:0] port_oe_o, // Low drives pin
	output logic osc_run_o, // Low in power-down
	output logic wdog_rst_o, // Chip reset pulse
	input rcdt_pkg::rcdt_axi_in_type axi_i, // Bus requests
	output rcdt_pkg::rcdt_axi_out_type axi_o // Bus answers
);
	import rcdt_pkg::*;

	rcdt_state_type s_reg;
	rcdt_state_type s_next;
	rcdt_state_type tmp;
	logic ex, take, wd_hit, t0_tick, t0_fw_wr, skp;
	logic rmw, wr_f, wr_w, dst, fz, fc, fdc, cnew, cin;
	logic [7:0] pend, opd, res, bop;
	logic [6:0] ea;
	logic [8:0] sum;
	logic [4:0] dsum;
	logic [9:0] last;

	// ****
	// Helpers
	// ****

	// Reset image, shared by async reset and guard timer reset
	function automatic rcdt_state_type rst_val();
		rcdt_state_type v;
		v = '0;
		v.port = `RCDT_PORT_RST;
		v.pc = `RCDT_PC_RST;
		return v;
	endfunction

	// Stack is a ring; overflow silently overwrites the oldest
	function automatic rcdt_state_type push(rcdt_state_type v, logic [12:0] a);
		v.stk[v.sp] = a;
		v.sp = (v.sp == 3'(`RCDT_STACK_DEPTH - 1)) ? 3'h0 : v.sp + 3'h1;
		return v;
	endfunction

	function automatic rcdt_state_type pop(rcdt_state_type v);
		v.sp = (v.sp == 3'h0) ? 3'(`RCDT_STACK_DEPTH - 1) : v.sp - 3'h1;
		v.pc = v.stk[v.sp];
		v.bubble = 1'b1;
		return v;
	endfunction

	// ****
	// Next state
	// ****
	always_comb begin
		s_next = s_reg;
		s_next.wd_rst = 1'b0;
		tmp = s_reg;
		axi_o = '0;
		ea = 7'h00;
		opd = 8'h00;
		res = 8'h00;
		rmw = 1'b0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		dst = 1'b0;
		fz = 1'b0;
		fc = 1'b0;
		fdc = 1'b0;
		cnew = 1'b0;
		skp = 1'b0;
		t0_tick = 1'b0;
		t0_fw_wr = 1'b0;
		pend = {irq_i, s_reg.t0f} & s_reg.bus.irq_en;

		// Bus slave; ready waits on ce_i so no handshake is lost
		axi_o.awready = ce_i & ~s_reg.bus.aw_got & ~s_reg.bus.bvalid;
		axi_o.wready = ce_i & ~s_reg.bus.w_got & ~s_reg.bus.bvalid;
		axi_o.arready = ce_i & ~s_reg.bus.rvalid;
		axi_o.bvalid = s_reg.bus.bvalid;
		axi_o.bresp = s_reg.bus.bresp;
		axi_o.rvalid = s_reg.bus.rvalid;
		axi_o.rdata = s_reg.bus.rdata;
		axi_o.rresp = s_reg.bus.rresp;
		if (axi_i.awvalid & axi_o.awready) begin
			s_next.bus.aw_got = 1'b1;
			s_next.bus.awa = axi_i.awaddr;
		end
		if (axi_i.wvalid & axi_o.wready) begin
			s_next.bus.w_got = 1'b1;
			s_next.bus.wd = axi_i.wdata;
			s_next.bus.ws = axi_i.wstrb;
		end
		if (s_reg.bus.aw_got & s_reg.bus.w_got) begin
			s_next.bus.aw_got = 1'b0;
			s_next.bus.w_got = 1'b0;
			s_next.bus.bvalid = 1'b1;
			s_next.bus.bresp = `RCDT_RESP_OKAY;
			case (s_reg.bus.awa)
				`RCDT_A_IRQ_EN: if (s_reg.bus.ws[0]) s_next.bus.irq_en = s_reg.bus.wd[7:0];
				`RCDT_A_CORE: begin
					// Write one clears; a rollover below still wins
					if (s_reg.bus.ws[2] & s_reg.bus.wd[`RCDT_CORE_T0F]) s_next.t0f = 1'b0;
				end
				`RCDT_A_PC, `RCDT_A_TIMER: ;
				default: s_next.bus.bresp = `RCDT_RESP_SLVERR;
			endcase
		end
		if (s_reg.bus.bvalid & axi_i.bready) s_next.bus.bvalid = 1'b0;
		if (axi_i.arvalid & axi_o.arready) begin
			s_next.bus.rvalid = 1'b1;
			s_next.bus.rresp = `RCDT_RESP_OKAY;
			case (axi_i.araddr)
				`RCDT_A_IRQ_EN: s_next.bus.rdata = {24'h000000, s_reg.bus.irq_en};
				`RCDT_A_CORE: s_next.bus.rdata = {12'h000, s_reg.t0f, s_reg.iflag,
					s_reg.wd_en, s_reg.sleep, s_reg.stat, s_reg.w};
				`RCDT_A_PC: s_next.bus.rdata = {19'h00000, s_reg.pc};
				`RCDT_A_TIMER: s_next.bus.rdata = {8'h00, s_reg.psc, s_reg.rld, s_reg.tmr};
				default: begin
					s_next.bus.rdata = 32'h00000000;
					s_next.bus.rresp = `RCDT_RESP_SLVERR;
				end
			endcase
		end
		if (s_reg.bus.rvalid & axi_i.rready) s_next.bus.rvalid = 1'b0;

		// Cycle qualifiers
		wd_hit = s_reg.wd_en & ~s_reg.sleep & (s_reg.wd_cnt == 22'(WDOG_LIMIT - 1));
		take = ~s_reg.sleep & ~s_reg.bubble & ~s_reg.iflag & (|pend);
		ex = ce_i & ~s_reg.sleep & ~s_reg.bubble & ~take & ~wd_hit;

		// Timer and guard timer; both stop with the oscillator
		last = 10'((({2'h0, s_reg.psc} + 10'h001) * `RCDT_T0_MIN_DIV) - 1); // [RULE_08]
		if (~s_reg.sleep) begin // [RULE_05]
			if (s_reg.pcnt >= last) begin // [RULE_08]
				s_next.pcnt = 10'h000;
				t0_tick = 1'b1;
			end else begin
				s_next.pcnt = s_reg.pcnt + 10'h001;
			end
			if (t0_tick & (s_reg.tmr == 8'hFF)) begin
				s_next.tmr = s_reg.rld; // [RULE_07]
				s_next.t0f = 1'b1; // [RULE_09]
			end else if (t0_tick) begin
				s_next.tmr = s_reg.tmr + 8'h01; // [RULE_07]
			end
			if (s_reg.wd_en) s_next.wd_cnt = s_reg.wd_cnt + 22'h000001; // [RULE_04]
		end
		if (s_reg.sleep & (|pend)) s_next.sleep = 1'b0; // [RULE_06]

		// Operand fetch; indirect through the select register
		ea = (instr_i[13:12] == 2'b01) ? {1'b0, instr_i[5:0]} : instr_i[6:0];
		if (ea == `RCDT_F_INDIR) ea = s_reg.fsr[6:0];
		rmw = ((instr_i[13:11] == 3'b010) & ~instr_i[10]) |
			((instr_i[13:12] == 2'b00) & instr_i[7]); // [RULE_10]
		case (ea)
			`RCDT_F_TIMER: opd = s_reg.tmr;
			`RCDT_F_PCL: opd = s_reg.pc[7:0];
			`RCDT_F_STAT: opd = s_reg.stat;
			`RCDT_F_FSR: opd = s_reg.fsr;
			`RCDT_F_PORT: opd = rmw ? s_reg.port : port_pin_i; // [RULE_10]
			default: opd = s_reg.gpr[ea[3:0]];
		endcase
		res = opd;

		// Shared adder: subtract is operand plus inverted W plus one
		cin = (instr_i[11:8] == 4'h2);
		bop = cin ? ~s_reg.w : s_reg.w;
		sum = {1'b0, opd} + {1'b0, bop} + {8'h00, cin};
		dsum = {1'b0, opd[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};

		// ****
		// Execute
		// ****
		if (take) begin
			// Inserted call to the interrupt vector
			s_next = push(s_next, s_reg.pc);
			s_next.pc = `RCDT_IRQ_VEC;
			s_next.iflag = 1'b1;
			s_next.bubble = 1'b1;
		end else if (s_reg.bubble & ~s_reg.sleep) begin
			s_next.bubble = 1'b0; // [RULE_25]
		end else if (ex) begin
			s_next.pc = s_reg.pc + 13'h0001;
			case (instr_i[13:12])
				2'b00: begin
					case (instr_i[11:8])
						4'h0: begin
							if (instr_i[7]) begin
								wr_f = 1'b1;
								res = s_reg.w;
							end else begin
								case (instr_i[6:0])
									`RCDT_SYS_SLEEP: s_next.sleep = 1'b1; // [RULE_01]
									`RCDT_SYS_KICK: begin
										s_next.wd_en = 1'b1; // [RULE_02]
										s_next.wd_cnt = 22'h000000; // [RULE_02]
									end
									`RCDT_SYS_RET: s_next = pop(s_next); // [RULE_27]
									`RCDT_SYS_IRQ_EXIT_OP: begin
										s_next = pop(s_next); // [RULE_27]
										s_next.iflag = 1'b0;
									end
									default: begin
										// Idle code lands on unmapped slot 0
										if (~instr_i[6] & (instr_i[5:0] == `RCDT_R_RELOAD))
											s_next.rld = s_reg.w; // [RULE_29]
										if (~instr_i[6] & (instr_i[5:0] == `RCDT_R_PRESCALE))
											s_next.psc = s_reg.w; // [RULE_29]
									end
								endcase
							end
						end
						4'h1: begin
							res = 8'h00;
							dst = 1'b1;
							fz = 1'b1;
						end
						4'h2, 4'h7: begin
							res = sum[7:0]; // [RULE_26]
							cnew = sum[8];
							dst = 1'b1;
							fz = 1'b1;
							fc = 1'b1;
							fdc = 1'b1;
						end
						4'h3, 4'hB: begin
							res = opd - 8'h01; // [RULE_26]
							dst = 1'b1;
							fz = 1'b1;
							skp = instr_i[11] & (res == 8'h00); // [RULE_13]
						end
						4'h4: begin
							res = opd | s_reg.w; // [RULE_26]
							dst = 1'b1;
							fz = 1'b1;
						end
						4'h5: begin
							res = opd & s_reg.w; // [RULE_26]
							dst = 1'b1;
							fz = 1'b1;
						end
						4'h6: begin
							res = opd ^ s_reg.w; // [RULE_26]
							dst = 1'b1;
							fz = 1'b1;
						end
						4'h8: begin
							fz = 1'b1; // [RULE_28]
							wr_w = ~instr_i[7]; // [RULE_28]
						end
						4'h9: begin
							res = ~opd; // [RULE_26]
							dst = 1'b1;
							fz = 1'b1;
						end
						4'hC: begin
							res = {s_reg.stat[`RCDT_ST_C], opd[7:1]}; // [RULE_11]
							cnew = opd[0];
							fc = 1'b1;
							dst = 1'b1;
						end
						4'hD: begin
							res = {opd[6:0], s_reg.stat[`RCDT_ST_C]}; // [RULE_11]
							cnew = opd[7];
							fc = 1'b1;
							dst = 1'b1;
						end
						4'hE: begin
							res = {opd[3:0], opd[7:4]}; // [RULE_12]
							dst = 1'b1;
						end
						default: begin
							res = opd + 8'h01; // [RULE_26]
							dst = 1'b1;
							fz = 1'b1;
							// Plain increment shares this branch and must never skip
							skp = (instr_i[11:8] == 4'hF) & (res == 8'h00); // [RULE_13]
						end
					endcase
					if (dst & instr_i[7]) wr_f = 1'b1; // [RULE_23]
					if (dst & ~instr_i[7]) wr_w = 1'b1; // [RULE_23]
				end
				2'b01: begin
					if (~instr_i[11]) begin
						case (instr_i[10:9])
							2'b00: begin
								res[instr_i[8:6]] = 1'b0; // [RULE_14]
								wr_f = 1'b1;
							end
							2'b01: begin
								res[instr_i[8:6]] = 1'b1; // [RULE_14]
								wr_f = 1'b1;
							end
							2'b10: skp = ~opd[instr_i[8:6]]; // [RULE_15]
							default: skp = opd[instr_i[8:6]]; // [RULE_16]
						endcase
					end else begin
						wr_w = 1'b1;
						case (instr_i[10:8])
							3'h0: begin
								s_next = pop(s_next); // [RULE_17]
								res = instr_i[7:0]; // [RULE_17]
							end
							3'h1: res = instr_i[7:0]; // [RULE_18]
							3'h2: begin
								res = s_reg.w | instr_i[7:0]; // [RULE_19]
								fz = 1'b1;
							end
							3'h3: res = s_reg.w & instr_i[7:0]; // [RULE_20]
							3'h4: res = s_reg.w + instr_i[7:0]; // [RULE_21]
							3'h7: begin
								res = s_reg.w ^ instr_i[7:0]; // [RULE_22]
								fz = 1'b1;
							end
							default: wr_w = 1'b0;
						endcase
					end
				end
				default: begin
					if (~instr_i[12]) s_next = push(s_next, s_next.pc); // [RULE_27]
					s_next.pc = {s_reg.stat[`RCDT_ST_PAGE], instr_i[11:0]}; // [RULE_24]
					s_next.bubble = 1'b1; // [RULE_25]
				end
			endcase

			// Skip burns the next slot as a dead cycle
			if (skp) begin
				s_next.pc = s_reg.pc + 13'h0002; // [RULE_13]
				s_next.bubble = 1'b1; // [RULE_25]
			end

			// Write back; flags go last so they beat a status write
			if (wr_f) begin
				case (ea)
					`RCDT_F_TIMER: begin
						s_next.tmr = res; // [RULE_07]
						t0_fw_wr = 1'b1;
					end
					`RCDT_F_PCL: begin
						s_next.pc = {s_reg.pc[12:8], res};
						s_next.bubble = 1'b1;
					end
					`RCDT_F_STAT: s_next.stat = res;
					`RCDT_F_FSR: s_next.fsr = res;
					`RCDT_F_PORT: s_next.port = res;
					default: s_next.gpr[ea[3:0]] = res;
				endcase
			end
			if (wr_w) s_next.w = res;
			if (fz) s_next.stat[`RCDT_ST_Z] = (res == 8'h00);
			if (fc) s_next.stat[`RCDT_ST_C] = cnew;
			if (fdc) s_next.stat[`RCDT_ST_DC] = dsum[4];
		end

		// Guard timer expiry restarts the core, the bus side survives
		if (wd_hit) begin
			tmp = rst_val(); // [RULE_03]
			tmp.bus = s_next.bus;
			tmp.wd_rst = 1'b1; // [RULE_04]
			s_next = tmp;
		end
	end

	// ****
	// State register
	// ****
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_reg <= rst_val(); // [RULE_03]
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// Outputs; open-drain pin driven only while its latch is low
	assign pc_o = s_reg.pc;
	assign port_out_o = s_reg.port;
	assign port_oe_o = s_reg.port;
	assign osc_run_o = ~s_reg.sleep;
	assign wdog_rst_o = s_reg.wd_rst;

	// ****
	// Checks
	// ****
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence sq_sleep_op;
		ex && (instr_i == {7'h00, `RCDT_SYS_SLEEP});
	endsequence
	sequence sq_wrap;
		ce_i && t0_tick && (s_reg.tmr == 8'hFF) && !t0_fw_wr && !wd_hit;
	endsequence
	property p_jump;
		logic [12:0] t;
		(ex && instr_i[13], t = {s_reg.stat[`RCDT_ST_PAGE], instr_i[11:0]})
			|=> (s_reg.pc == t) && s_reg.bubble;
	endproperty

	AST_SLEEP_ENTRY: assert property (sq_sleep_op |=> !osc_run_o) // [RULE_01]
		else $error("sleep opcode did not stop the oscillator");
	AST_KICK: assert property (ex && (instr_i == {7'h00, `RCDT_SYS_KICK})
		|=> s_reg.wd_en && (s_reg.wd_cnt == 22'h000000)) // [RULE_02]
		else $error("kick did not clear and enable guard timer");
	AST_WD_OFF: assert property (wdog_rst_o |-> !s_reg.wd_en) // [RULE_03]
		else $error("guard timer still enabled after its reset");
	AST_WD_FIRE: assert property (ce_i && wd_hit
		|=> wdog_rst_o && (s_reg.pc == `RCDT_PC_RST)) // [RULE_04]
		else $error("guard timer expiry gave no chip reset");
	AST_WD_FREEZE: assert property (s_reg.sleep |=> $stable(s_reg.wd_cnt)) // [RULE_05]
		else $error("guard timer counted in power-down");
	AST_WAKE: assert property (s_reg.sleep && ce_i && (|pend) |=> !s_reg.sleep) // [RULE_06]
		else $error("enabled interrupt did not end power-down");
	AST_RELOAD: assert property (sq_wrap |=> s_reg.t0f && (s_reg.tmr == $past(s_reg.rld))) // [RULE_09]
		else $error("timer rollover did not reload and flag");
	AST_SKIP: assert property (ex && skp
		|=> s_reg.bubble && (s_reg.pc == $past(s_reg.pc) + 13'h0002)) // [RULE_15]
		else $error("skip did not pass over the next word");
	AST_JUMP: assert property (p_jump) // [RULE_24]
		else $error("call or jump target wrong");

endmodule

// ### verif/rcdt_rom.sv
// Purpose: program store model feeding the core its instruction words
// Assumes: bench fills mem while the core is held in reset
// Notes: answers in the same cycle, like an asynchronous ROM
`timescale 1ns/10ps
module rcdt_rom (
	input wire logic [12:0] addr_i, // Fetch address
	output logic [13:0] instr_o // Word at addr_i
);
	logic [13:0] mem [0:8191];

	// ****
	// Storage
	// ****
	// Unwritten words read as the idle opcode, never as unknowns
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 14'h0000;
		end
	end

	// No latency: the core expects the word in the fetch cycle
	assign instr_o = mem[addr_i];
endmodule

// ### verif/rcdt_core_tb.sv
// Purpose: self-checking bench of the decode, power-down and timer core
// Assumes: programs are placed in the store model while reset is low
// Notes: guard span cut to 64 cycles so expiry fits a short run
`timescale 1ns/10ps
module rcdt_core_tb;
	import rcdt_pkg::*;
	localparam logic [13:0] LDF = 14'h190F; // W = 0F
	localparam logic [13:0] STF = 14'h00A0; // Scratch byte = W
	localparam logic [13:0] LDC = 14'h193C; // W = 3C
	localparam logic [13:0] IDL = 14'h0000; // Idle
	typedef struct packed {
		logic [0:3][13:0] op;
		logic [7:0] w;
		logic [2:0] st;
		logic [2:0] m;
		logic [7:0] port;
	} rcdt_row_type;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic [6:0] irq = 7'h00;
	rcdt_axi_in_type ai = '0;
	rcdt_axi_out_type ao;
	logic [13:0] instr;
	logic [12:0] pc;
	logic [7:0] port_pin, port_out, port_oe;
	logic osc_run, wdog_rst;
	logic [31:0] d, t1;
	logic [1:0] r;
	logic [12:0] p;
	int num_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int pulses = 0;
	int n;
	rcdt_row_type rows [30] = '{
		'{'{14'h19FF, STF, 14'h0AA0, 14'h1C01}, 8'h00, 3'h4, 3'h4, 8'hFF}, // [26] [13]
		'{'{LDF, STF, LDC, 14'h0220}, 8'hD3, 3'h2, 3'h7, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h0320}, 8'h0E, 3'h0, 3'h0, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h0420}, 8'h3F, 3'h0, 3'h4, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h0520}, 8'h0C, 3'h0, 3'h4, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h0620}, 8'h33, 3'h0, 3'h4, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h0720}, 8'h4B, 3'h2, 3'h7, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h08A0}, 8'h3C, 3'h0, 3'h4, 8'hFF}, // [28]
		'{'{LDF, STF, LDC, 14'h0920}, 8'hF0, 3'h0, 3'h0, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h0A20}, 8'h10, 3'h0, 3'h0, 8'hFF}, // [26]
		'{'{LDF, STF, LDC, 14'h0C20}, 8'h07, 3'h1, 3'h1, 8'hFF}, // [11]
		'{'{LDF, STF, LDC, 14'h0D20}, 8'h1E, 3'h0, 3'h1, 8'hFF}, // [11]
		'{'{LDF, STF, LDC, 14'h0E20}, 8'hF0, 3'h0, 3'h0, 8'hFF}, // [12]
		'{'{14'h195A, 14'h1A0F, IDL, IDL}, 8'h5F, 3'h0, 3'h4, 8'hFF}, // [18] [19] [29]
		'{'{14'h19F0, 14'h1B3C, IDL, IDL}, 8'h30, 3'h0, 3'h0, 8'hFF}, // [20]
		'{'{14'h1970, 14'h1C95, IDL, IDL}, 8'h05, 3'h0, 3'h0, 8'hFF}, // [21]
		'{'{14'h19A5, 14'h1FA5, IDL, IDL}, 8'h00, 3'h4, 3'h4, 8'hFF}, // [22]
		'{'{14'h1911, 14'h2005, 14'h1C01, IDL}, 8'h43, 3'h0, 3'h0, 8'hFF}, // [17] [27]
		'{'{14'h1901, STF, 14'h0BA0, 14'h1C10}, 8'h01, 3'h0, 3'h0, 8'hFF}, // [13]
		'{'{14'h1902, STF, 14'h0BA0, 14'h1C10}, 8'h12, 3'h0, 3'h0, 8'hFF}, // [13] [23]
		'{'{14'h19FF, STF, 14'h0FA0, 14'h1C10}, 8'hFF, 3'h0, 3'h0, 8'hFF}, // [13]
		'{'{14'h1900, STF, 14'h12E0, 14'h0820}, 8'h08, 3'h0, 3'h0, 8'hFF}, // [14]
		'{'{14'h19FF, STF, 14'h11E0, 14'h0820}, 8'h7F, 3'h0, 3'h0, 8'hFF}, // [14]
		'{'{14'h19FE, STF, 14'h1420, 14'h1C01}, 8'hFE, 3'h0, 3'h0, 8'hFF}, // [15]
		'{'{14'h1901, STF, 14'h1420, 14'h1C01}, 8'h02, 3'h0, 3'h0, 8'hFF}, // [15]
		'{'{14'h1901, STF, 14'h1620, 14'h1C01}, 8'h01, 3'h0, 3'h0, 8'hFF}, // [16]
		'{'{LDF, STF, 14'h0EA0, 14'h0820}, 8'hF0, 3'h0, 3'h0, 8'hFF}, // [12] [23]
		'{'{14'h1981, STF, 14'h0CA0, 14'h0820}, 8'h40, 3'h1, 3'h1, 8'hFF}, // [11] [23]
		'{'{14'h0806, IDL, IDL, IDL}, 8'h0F, 3'h0, 3'h0, 8'hFF}, // [10]
		'{'{14'h11C6, 14'h0806, IDL, IDL}, 8'h0F, 3'h0, 3'h0, 8'h7F} // [10]
	};

	// ****
	// Design, store model and pins
	// ****
	// Pins 7:4 held low outside; a driven bit pulls its pin low too
	assign port_pin = port_oe & 8'h0F;
	rcdt_rom u_rcdt_rom (.addr_i(pc), .instr_o(instr));
	rcdt_core #(.WDOG_LIMIT(64)) u_rcdt_core (
		.ref_clk_i(ref_clk),
		.resetn_i(resetn),
		.ce_i(ce),
		.instr_i(instr),
		.pc_o(pc),
		.irq_i(irq),
		.port_pin_i(port_pin),
		.port_out_o(port_out),
		.port_oe_o(port_oe),
		.osc_run_o(osc_run),
		.wdog_rst_o(wdog_rst),
		.axi_i(ai),
		.axi_o(ao)
	);

	// ****
	// Clock, watchdogs and helpers
	// ****
	// 200 MHz core clock
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Run ceiling: the whole sequence needs well under 5000 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	// Guard expiry pulses, sampled mid-cycle to stay clear of the edge
	always @(negedge ref_clk) begin
		if (wdog_rst === 1'b1) begin
			pulses++;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic complete_run();
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Readies are combinational, so they are judged mid-cycle where stable
	task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
		logic aw, w, b;
		@(posedge ref_clk);
		ai.awvalid <= 1'b1;
		ai.awaddr <= a;
		ai.wvalid <= 1'b1;
		ai.wdata <= wd;
		ai.wstrb <= s;
		ai.bready <= 1'b1;
		do begin
			@(negedge ref_clk);
			aw = ai.awvalid & ao.awready;
			w = ai.wvalid & ao.wready;
			b = ao.bvalid;
			r = ao.bresp;
			@(posedge ref_clk);
			if (aw) begin
				ai.awvalid <= 1'b0;
			end
			if (w) begin
				ai.wvalid <= 1'b0;
			end
		end while (b !== 1'b1);
		ai.bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a);
		logic ar, v;
		@(posedge ref_clk);
		ai.arvalid <= 1'b1;
		ai.araddr <= a;
		ai.rready <= 1'b1;
		do begin
			@(negedge ref_clk);
			ar = ai.arvalid & ao.arready;
			v = ao.rvalid;
			d = ao.rdata;
			r = ao.rresp;
			@(posedge ref_clk);
			if (ar) begin
				ai.arvalid <= 1'b0;
			end
		end while (v !== 1'b1);
		ai.rready <= 1'b0;
	endtask

	// Program is loaded mid-cycle while reset holds the fetch address
	task automatic run_prog(input logic [0:3][13:0] op, input int cycles);
		@(posedge ref_clk);
		resetn <= 1'b0;
		@(negedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			u_rcdt_rom.mem[i] = op[i];
		end
		u_rcdt_rom.mem[4] = 14'h3004;
		u_rcdt_rom.mem[5] = 14'h1842;
		@(posedge ref_clk);
		resetn <= 1'b1;
		pulses = 0;
		repeat (cycles) @(posedge ref_clk);
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({pc, port_out, port_oe, osc_run, wdog_rst}, {13'h0000, 16'hFFFF, 2'h2});
		@(posedge ref_clk);
		resetn <= 1'b1;
		axi_read(8'h04);
		chk(32'(d[19:16]), 32'h0);
		axi_read(8'h0C);
		chk(32'(d[23:8]), 32'h0);
		axi_read(8'h10);
		chk({d[29:0], r}, 32'h2);
		axi_write(8'h08, 32'h0000_0055, 4'hF);
		chk(32'(r), 32'h0);
		for (int i = 0; i < 30; i++) begin
			run_prog(rows[i].op, 16);
			axi_read(8'h04);
			chk(32'(d[7:0]), 32'(rows[i].w));
			chk(32'(d[10:8] & rows[i].m), 32'(rows[i].st & rows[i].m));
			chk(32'(port_out), 32'(rows[i].port));
			axi_read(8'h08);
			chk(d, 32'h0000_0004);
		end
		// Sleep, refuse a disabled source, wake on an enabled one
		run_prog('{14'h0003, 14'h1977, 14'h3002, IDL}, 10);
		@(negedge ref_clk);
		p = pc;
		chk(32'(osc_run), 32'h0);
		@(posedge ref_clk);
		irq <= 7'h01;
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({pc, osc_run}, {p, 1'b0});
		axi_write(8'h00, 32'h0000_0002, 4'h1);
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'(osc_run), 32'h1);
		axi_read(8'h04);
		irq <= 7'h00;
		chk(32'({d[18], d[16], d[7:0]}), 32'h277);
		// Guard timer: frozen in sleep, off until kicked, kicks hold it off
		run_prog('{14'h0004, 14'h0003, IDL, IDL}, 200);
		chk(pulses, 32'h0);
		axi_read(8'h04);
		chk(32'(d[17:16]), 32'h3);
		run_prog('{14'h3000, IDL, IDL, IDL}, 200);
		chk(pulses, 32'h0);
		run_prog('{14'h0004, 14'h3000, IDL, IDL}, 200);
		chk(pulses, 32'h0);
		run_prog('{14'h0004, 14'h3001, IDL, IDL}, 0);
		n = 0;
		while (wdog_rst !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(n >= 64 && n <= 70), 32'h1);
		// Timer reload at rollover, flag set then cleared by software
		run_prog('{14'h19F0, 14'h0001, 14'h19FE, 14'h0081}, 12);
		axi_read(8'h0C);
		chk(32'(d[23:8]), 32'h00F0);
		chk(32'(d[7:0] >= 8'hF0 && d[7:0] < 8'hFE), 32'h1);
		axi_read(8'h04);
		chk(32'(d[19]), 32'h1);
		axi_write(8'h04, 32'h0008_0000, 4'h4);
		axi_read(8'h04);
		chk(32'(d[19]), 32'h0);
		// Prescale 1 gives one step per 8 cycles
		run_prog('{14'h1901, 14'h0002, IDL, IDL}, 4);
		axi_read(8'h0C);
		t1 = d;
		repeat (77) @(posedge ref_clk);
		axi_read(8'h0C);
		chk(32'(d[23:16]), 32'h01);
		chk(32'(d[7:0] - t1[7:0] >= 8'h09 && d[7:0] - t1[7:0] <= 8'h0B), 32'h1);
		// Page bit supplies the top bit of a jump target
		u_rcdt_rom.mem[13'h1007] = 14'h3007;
		run_prog('{14'h1383, 14'h3007, IDL, IDL}, 10);
		axi_read(8'h08);
		chk(d, 32'h0000_1007);
		complete_run();
	end
endmodule
